// *** common/qbp_regs.vh ***
/*
 Timing counts and reset values for the quasi-bidirectional port block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef QBP_REGS_VH
`define QBP_REGS_VH
`define QBP_CLK_HZ 10000000
`define QBP_BOOST_CYCLES 2
`define QBP_LATCH_RESET 8'hFF
`define QBP_MODE_PORT 2'h0
`define QBP_MODE_NONPAGED 2'h1
`define QBP_MODE_PAGE1 2'h2
`define QBP_MODE_PAGE2 2'h3
`define QBP_BIT_T3IO 0
`define QBP_BIT_T3TRIG 1
`define QBP_BIT_SBRX 2
`define QBP_BIT_SBTX 3
`define QBP_BIT_IRQ2 4
`define QBP_BIT_IRQ3 5
`define QBP_BIT_IRQ4 6
`define QBP_BIT_IRQ5 7
`endif

// *** verilog/qbp_pin_cell.v ***
/*
 One quasi-bidirectional pin: latch, strong pulldown, momentary boost,
 weak pullup, two-flop input synchroniser.
 Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "qbp_regs.vh"
module qbp_pin_cell #(
   parameter BOOST = `QBP_BOOST_CYCLES
) (
   input wire clock,
   input wire rst,
   input wire wr_en,
   input wire wr_val,
   input wire alt_en,
   input wire alt_val,
   input wire pin_in,
   output reg pin_out,
   output reg pin_oe,
   output reg weak_pu,
   output reg latch,
   output reg pin_sync
);
   reg sync_a;
   reg [3:0] boost_cnt;
   wire drive_val;
   // Alternate function overrides latch; latch value is ignored while it is on
   assign drive_val = alt_en ? alt_val : latch;

   // Latch and boost timer
   always @(posedge clock) begin
      if (rst) begin
         latch <= 1'b1; // R1 R2
         boost_cnt <= 4'h0;
      end else begin
         if (wr_en) begin
            latch <= wr_val; // R4
         end
         if (wr_en && wr_val && !latch) begin
            boost_cnt <= BOOST[3:0]; // R5 R18
         end else if (boost_cnt != 4'h0) begin
            boost_cnt <= boost_cnt - 4'h1;
         end
      end
   end

   // Pin drivers: low is strong, high strong only during boost or an alternate function
   always @(posedge clock) begin
      if (rst) begin
         pin_out <= 1'b1;
         pin_oe <= 1'b0;
         weak_pu <= 1'b1;
      end else begin
         pin_out <= drive_val;
         pin_oe <= !drive_val || alt_en || (boost_cnt != 4'h0); // R4 R5
         weak_pu <= 1'b1; // R3
      end
   end

   // Two-flop synchroniser so pin reads as input level
   always @(posedge clock) begin
      if (rst) begin
         sync_a <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         sync_a <= pin_in;
         pin_sync <= sync_a; // R3
      end
   end
endmodule // qbp_pin_cell
`default_nettype wire

// *** verilog/qbp_ports.v ***
/*
 Quasi-bidirectional upper-address port, strobe/serial port, and the
 alternate functions of the first port's pins.
 Assumes CPU latch writes and memory controls on the core clock; pins
 asynchronous and resolved outside from out/oe plus weak pullup.
*/
// Functional notes
// R1: Upper-address port resets with all latches high, weak pullup only.
// R2: Strobe/serial port resets with all eight latches at one.
// R3: Latched-high pin acts as input; device reads the actual level.
// R4: Writing zero enables strong pulldown until one is written or reset.
// R5: Zero-to-one write briefly drives strong high, then weak pullup.
// R6: External fetch or data access drives high address byte on upper port.
// R7: Page mode one multiplexes high and low address bytes on upper port.
// R8: Page mode two carries high address byte and data byte.
// R9: First port bit one feeds timer three capture/reload trigger.
// R10: First port bit two carries second serial channel receive.
// R11: First port bit three drives second serial channel transmit.
// R12: Interrupts two and four detect rising edges on bits four, six.
// R13: Interrupts three and five detect falling edges on bits five, seven.
// R14: Strobe port offers legacy irqs, serial A, timer inputs, strobes.
// R15: Strobe port bit zero carries first serial channel receive.
// R16: Strobe bit one drives serial A transmit; bits six, seven strobes.
// R17: First port bit zero is timer three external input/output.
// R18: Momentary strong high lasts a fixed short count of core clocks.
// R19: Extra interrupt pins synchronised; one pending pulse per edge.
`timescale 1ns/10ps
`default_nettype none
`include "qbp_regs.vh"
module qbp_ports #(
   parameter BOOST = `QBP_BOOST_CYCLES
) (
   input wire clock,
   input wire rst,
   // Upper-address port
   input wire up_wr_en,
   input wire [7:0] up_wr_data,
   input wire [1:0] mem_mode,
   input wire mem_active,
   input wire addr_phase_low,
   input wire data_phase,
   input wire [15:0] mem_addr,
   input wire data_dir_out,
   input wire [7:0] mem_wdata,
   input wire [7:0] up_pin_in,
   output wire [7:0] up_pin_out,
   output wire [7:0] up_pin_oe,
   output wire [7:0] up_weak_pu,
   output wire [7:0] up_latch,
   output wire [7:0] up_pin_level,
   // Strobe/serial port
   input wire ss_wr_en,
   input wire [7:0] ss_wr_data,
   input wire serial_a_active,
   input wire serial_a_transmit,
   input wire ext_wr_strobe_n,
   input wire ext_rd_strobe_n,
   input wire strobes_active,
   input wire [7:0] ss_pin_in,
   output wire [7:0] ss_pin_out,
   output wire [7:0] ss_pin_oe,
   output wire [7:0] ss_weak_pu,
   output wire [7:0] ss_latch,
   output wire [7:0] ss_pin_level,
   output reg serial_a_receive,
   // First port alternates
   input wire timer3_out_en,
   input wire timer3_out_val,
   input wire serial_b_active,
   input wire serial_b_transmit,
   input wire [7:0] fp_pin_in,
   output reg [7:0] fp_alt_en,
   output reg [7:0] fp_alt_val,
   output reg timer3_external_io,
   output reg timer3_capture_trigger_in,
   output reg serial_b_receive,
   output reg ext_irq_two_rise,
   output reg ext_irq_three_fall,
   output reg ext_irq_four_rise,
   output reg ext_irq_five_fall
);
   reg [7:0] up_alt_val;
   reg up_alt_en;
   reg [7:0] ss_alt_en;
   reg [7:0] ss_alt_val;
   reg [7:0] fp_s1;
   reg [7:0] fp_s2;
   reg [7:0] fp_prev;
   wire [3:0] irq_edge;
   genvar i;

   // Upper-address port bus source by memory mode
   always @* begin
      up_alt_en = mem_active && (mem_mode != `QBP_MODE_PORT); // R6
      up_alt_val = mem_addr[15:8]; // R6
      if (mem_mode == `QBP_MODE_PAGE1 && addr_phase_low) begin
         up_alt_val = mem_addr[7:0]; // R7
      end else if (mem_mode == `QBP_MODE_PAGE2 && data_phase) begin
         up_alt_val = mem_wdata; // R8
         up_alt_en = mem_active && data_dir_out; // Read phase gives pins back to their latches
      end
   end

   // Strobe/serial port alternates; inputs use the latch-high state
   // Bit zero and the legacy irq and timer pins stay released, read back as inputs
   always @* begin
      ss_alt_en = 8'h00; // R14
      ss_alt_val = 8'hFF;
      ss_alt_en[1] = serial_a_active; // R16
      ss_alt_val[1] = serial_a_transmit; // R16
      ss_alt_en[6] = strobes_active; // R16
      ss_alt_val[6] = ext_wr_strobe_n; // R16
      ss_alt_en[7] = strobes_active; // R16
      ss_alt_val[7] = ext_rd_strobe_n; // R16
   end

   // One cell per pin on each port; a port write strobe reaches all eight
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_pin
         qbp_pin_cell #(.BOOST(BOOST)) u_up (
            .clock(clock),
            .rst(rst),
            .wr_en(up_wr_en),
            .wr_val(up_wr_data[i]),
            .alt_en(up_alt_en),
            .alt_val(up_alt_val[i]),
            .pin_in(up_pin_in[i]),
            .pin_out(up_pin_out[i]),
            .pin_oe(up_pin_oe[i]),
            .weak_pu(up_weak_pu[i]),
            .latch(up_latch[i]),
            .pin_sync(up_pin_level[i])
         );
         qbp_pin_cell #(.BOOST(BOOST)) u_ss (
            .clock(clock),
            .rst(rst),
            .wr_en(ss_wr_en),
            .wr_val(ss_wr_data[i]),
            .alt_en(ss_alt_en[i]),
            .alt_val(ss_alt_val[i]),
            .pin_in(ss_pin_in[i]),
            .pin_out(ss_pin_out[i]),
            .pin_oe(ss_pin_oe[i]),
            .weak_pu(ss_weak_pu[i]),
            .latch(ss_latch[i]),
            .pin_sync(ss_pin_level[i])
         );
      end
   endgenerate

   // Serial A receive from synchronised bit zero
   // Idles high when serial A is off, so the receiver sees a stop level
   always @(posedge clock) begin
      if (rst) begin
         serial_a_receive <= 1'b1;
      end else begin
         serial_a_receive <= serial_a_active ? ss_pin_level[0] : 1'b1; // R15
      end
   end

   // First port output overrides, registered to the pin cells outside
   // Unused bits default to released with a high value, so they read as inputs
   always @(posedge clock) begin
      if (rst) begin
         fp_alt_en <= 8'h00;
         fp_alt_val <= 8'hFF;
      end else begin
         fp_alt_en <= 8'h00;
         fp_alt_val <= 8'hFF;
         fp_alt_en[`QBP_BIT_T3IO] <= timer3_out_en; // R17
         fp_alt_val[`QBP_BIT_T3IO] <= timer3_out_val; // R17
         fp_alt_en[`QBP_BIT_SBTX] <= serial_b_active; // R11
         fp_alt_val[`QBP_BIT_SBTX] <= serial_b_transmit; // R11
      end
   end

   // Two-flop sync then edge detect; first flop feeds only the second
   // Reset to ones, the pulled-up idle level, so no false edge follows reset
   always @(posedge clock) begin
      if (rst) begin
         fp_s1 <= 8'hFF;
         fp_s2 <= 8'hFF;
         fp_prev <= 8'hFF;
      end else begin
         fp_s1 <= fp_pin_in;
         fp_s2 <= fp_s1; // R19
         fp_prev <= fp_s2;
      end
   end

   // Edge detect: rise on bits four and six, fall on five and seven
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_edge
         if (i % 2 == 0) begin : g_rise
            assign irq_edge[i] = fp_s2[`QBP_BIT_IRQ2 + i] & ~fp_prev[`QBP_BIT_IRQ2 + i]; // R12
         end else begin : g_fall
            assign irq_edge[i] = ~fp_s2[`QBP_BIT_IRQ2 + i] & fp_prev[`QBP_BIT_IRQ2 + i]; // R13
         end
      end
   endgenerate

   // Inputs and one-cycle interrupt event pulses
   always @(posedge clock) begin
      if (rst) begin
         timer3_external_io <= 1'b1;
         timer3_capture_trigger_in <= 1'b1;
         serial_b_receive <= 1'b1;
         ext_irq_two_rise <= 1'b0;
         ext_irq_three_fall <= 1'b0;
         ext_irq_four_rise <= 1'b0;
         ext_irq_five_fall <= 1'b0;
      end else begin
         timer3_external_io <= fp_s2[`QBP_BIT_T3IO]; // R17
         timer3_capture_trigger_in <= fp_s2[`QBP_BIT_T3TRIG]; // R9
         serial_b_receive <= serial_b_active ? fp_s2[`QBP_BIT_SBRX] : 1'b1; // R10
         ext_irq_two_rise <= irq_edge[0]; // R12
         ext_irq_four_rise <= irq_edge[2]; // R12
         ext_irq_three_fall <= irq_edge[1]; // R13
         ext_irq_five_fall <= irq_edge[3]; // R13
      end
   end
endmodule // qbp_ports
`default_nettype wire

// *** dv/qbp_board.sv ***
/* Board model: weak pullups on both ports, external pull-low loads on strobe port pins only.
 Assumes the bench sets ext_low; strong drive always wins. */
`timescale 1ns/10ps
`default_nettype none
module qbp_board (
   input wire logic [7:0] up_pin_out,
   input wire logic [7:0] up_pin_oe,
   input wire logic [7:0] ss_pin_out,
   input wire logic [7:0] ss_pin_oe,
   input wire logic [7:0] ext_low,
   output logic [7:0] up_pin_in,
   output logic [7:0] ss_pin_in
);
   // Undriven pins float high; on the strobe port a load can overcome the pullup
   assign up_pin_in = (up_pin_oe & up_pin_out) | ~up_pin_oe;
   assign ss_pin_in = (ss_pin_oe & ss_pin_out) | (~ss_pin_oe & ~ext_low);
endmodule // qbp_board
`default_nettype wire

// *** dv/qbp_ports_assertions.sv ***
/* Checker for the port block: reset, drive, sync and edge timing.
 Assumes a bind into qbp_ports with the default boost count. */
`timescale 1ns/10ps
`default_nettype none
module qbp_ports_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic mem_active,
   input wire logic [1:0] mem_mode,
   input wire logic addr_phase_low,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] ss_pin_in,
   input wire logic [7:0] up_pin_out,
   input wire logic [7:0] up_pin_oe,
   input wire logic [7:0] up_latch,
   input wire logic [7:0] ss_pin_out,
   input wire logic [7:0] ss_pin_oe,
   input wire logic [7:0] ss_latch,
   input wire logic [7:0] ss_pin_level,
   input wire logic [7:0] fp_pin_in,
   input wire logic ext_irq_two_rise
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_up_rst; $past(rst) |-> up_latch == 8'hff && up_pin_oe == 8'h00; endproperty
   a_up_rst: assert property (p_up_rst) else $error("upper port reset");
   property p_ss_rst; $past(rst) |-> ss_latch == 8'hff && ss_pin_oe == 8'h00; endproperty
   a_ss_rst: assert property (p_ss_rst) else $error("strobe port reset");
   property p_pull; !ss_latch[2] |=> ss_pin_oe[2] && !ss_pin_out[2]; endproperty
   a_pull: assert property (p_pull) else $error("pulldown missing");
   // Boost must end, or a stuck driver fights external loads
   property p_boost; $rose(ss_latch[2]) |=> (ss_pin_oe[2] && ss_pin_out[2])[*2] ##1 !ss_pin_oe[2];
   endproperty
   a_boost: assert property (p_boost) else $error("boost length");
   property p_sync; $fell(ss_pin_in[3]) ##1 (!ss_pin_in[3])[*3] |-> !ss_pin_level[3]; endproperty
   a_sync: assert property (p_sync) else $error("pin level not read");
   property p_hi; mem_active && mem_mode == 2'h1
      |=> up_pin_out == $past(mem_addr[15:8]); endproperty
   a_hi: assert property (p_hi) else $error("high address byte");
   property p_lo; mem_active && mem_mode == 2'h2 && addr_phase_low
      |=> up_pin_out == $past(mem_addr[7:0]); endproperty
   a_lo: assert property (p_lo) else $error("low address byte");
   property p_rise; $rose(fp_pin_in[4]) ##1 fp_pin_in[4][*3] |-> ##[0:2] ext_irq_two_rise;
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge lost");
   c_boost: cover property ($rose(ss_latch[2]));
   c_irq: cover property (ext_irq_two_rise);
   c_page: cover property (mem_active && mem_mode == 2'h2);
endmodule // qbp_ports_chk
bind qbp_ports qbp_ports_chk i_chk (.clock, .rst, .mem_active, .mem_mode, .addr_phase_low,
   .mem_addr, .ss_pin_in, .up_pin_out, .up_pin_oe, .up_latch, .ss_pin_out, .ss_pin_oe,
   .ss_latch, .ss_pin_level, .fp_pin_in, .ext_irq_two_rise);
`default_nettype wire

// *** dv/quasi_bidir_port_pins_bench.sv ***
/* Bench for qbp_ports: reset, pulldown, boost, inputs, memory bytes,
 edge interrupts, alternates. Assumes board model and checker. */
`timescale 1ns/10ps
`default_nettype none
module quasi_bidir_port_pins_bench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic up_wr_en, ss_wr_en, mem_active, addr_phase_low, serial_a_active, serial_a_transmit;
   logic ext_wr_strobe_n, ext_rd_strobe_n, strobes_active, serial_b_active, serial_b_transmit;
   logic serial_a_receive, timer3_external_io, timer3_capture_trigger_in, serial_b_receive;
   logic ext_irq_two_rise, ext_irq_three_fall, ext_irq_four_rise, ext_irq_five_fall;
   logic [1:0] mem_mode;
   logic [15:0] mem_addr;
   logic [7:0] up_wr_data, ss_wr_data, fp_pin_in, ext_low, up_pin_in, ss_pin_in, fp_alt_en;
   logic [7:0] up_pin_out, up_pin_oe, up_weak_pu, up_latch, up_pin_level, fp_alt_val;
   logic [7:0] ss_pin_out, ss_pin_oe, ss_weak_pu, ss_latch, ss_pin_level;
   logic data_phase, data_dir_out, timer3_out_en, timer3_out_val;
   logic [7:0] mem_wdata;
   logic [15:0] irq_tally;
   int error_cnt = 0;
   int checks_done = 0;
   int irq_cnt [4];
   qbp_ports i_dut (.clock, .rst, .up_wr_en, .up_wr_data, .mem_mode, .mem_active,
      .addr_phase_low, .data_phase, .mem_addr, .data_dir_out, .mem_wdata,
      .up_pin_in, .up_pin_out, .up_pin_oe, .up_weak_pu, .up_latch, .up_pin_level, .ss_wr_en,
      .ss_wr_data, .serial_a_active, .serial_a_transmit, .ext_wr_strobe_n, .ext_rd_strobe_n,
      .strobes_active, .ss_pin_in, .ss_pin_out, .ss_pin_oe, .ss_weak_pu, .ss_latch,
      .ss_pin_level, .serial_a_receive, .timer3_out_en, .timer3_out_val,
      .serial_b_active, .serial_b_transmit, .fp_pin_in, .fp_alt_en, .fp_alt_val,
      .timer3_external_io, .timer3_capture_trigger_in, .serial_b_receive, .ext_irq_two_rise,
      .ext_irq_three_fall, .ext_irq_four_rise, .ext_irq_five_fall);
   qbp_board i_board (.up_pin_out, .up_pin_oe, .ss_pin_out, .ss_pin_oe, .ext_low, .up_pin_in,
      .ss_pin_in);
   always #50 clock = ~clock;
   // Tally pulses, so a doubled or missing one shows
   always @(posedge clock) begin
      irq_cnt <= '{irq_cnt[0] + ext_irq_two_rise, irq_cnt[1] + ext_irq_three_fall,
         irq_cnt[2] + ext_irq_four_rise, irq_cnt[3] + ext_irq_five_fall};
   end
   assign irq_tally = {irq_cnt[3][3:0], irq_cnt[2][3:0], irq_cnt[1][3:0], irq_cnt[0][3:0]};
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   // One-cycle latch write; s picks the upper port
   task automatic wr(input logic s, input logic [7:0] d);
      if (s) {up_wr_en, up_wr_data} = {1'b1, d};
      else {ss_wr_en, ss_wr_data} = {1'b1, d};
      cyc(1);
      if (s) up_wr_en = 1'b0;
      else ss_wr_en = 1'b0;
   endtask
   task automatic t_pull;
      wr(1'b1, 8'h5a);
      wr(1'b0, 8'hfb);
      cyc(1);
      chk("up pulldown", up_pin_oe & ~up_pin_out, 8'ha5);
      cyc(1);
      chk("ss pulldown", {ss_pin_oe[2], ss_pin_out[2]}, 2'b10);
      cyc(3);
      chk("ss level", ss_pin_level, 8'hfb);
      chk("up level", up_pin_level, 8'h5a);
      wr(1'b0, 8'hff);
      cyc(2);
      chk("ss boost", {ss_pin_oe[2], ss_pin_out[2]}, 2'b11);
      cyc(2);
      chk("ss weak", {ss_pin_oe[2], ss_weak_pu[2]}, 2'b01);
   endtask
   task automatic t_input;
      ext_low = 8'h09;
      {serial_a_active, strobes_active, ext_wr_strobe_n} = 3'b111;
      cyc(4);
      chk("ss ext low", ss_pin_level, 8'h74);
      chk("serial a rx", serial_a_receive, 1'b0);
      chk("ss alt out", {ss_pin_out[7:6], ss_pin_out[1]}, 3'b010);
      ext_low = 8'h00;
   endtask
   task automatic t_mem;
      {mem_active, mem_mode, mem_addr} = {3'b101, 16'h3ca5};
      cyc(1);
      chk("addr high", up_pin_out, 8'h3c);
      {mem_mode, addr_phase_low} = 3'b101;
      cyc(1);
      chk("addr low", up_pin_out, 8'ha5);
      addr_phase_low = 1'b0;
      cyc(1);
      chk("page high", up_pin_out, 8'h3c);
      {mem_mode, data_phase, data_dir_out, mem_wdata} = {2'h3, 2'b11, 8'h96};
      cyc(1);
      chk("page2 data", up_pin_out, 8'h96);
      data_dir_out = 1'b0;
      cyc(1);
      chk("page2 read", up_pin_oe, 8'ha5);
      data_phase = 1'b0;
      cyc(1);
      chk("page2 high", up_pin_out, 8'h3c);
      mem_active = 1'b0;
   endtask
   // Wrong-direction edges on the way back must add nothing
   task automatic t_irq;
      logic [15:0] base;
      base = irq_tally;
      fp_pin_in = 8'h50;
      cyc(8);
      chk("irq tally", irq_tally - base, 16'h1111);
      fp_pin_in = 8'ha0;
      cyc(8);
      chk("irq back", irq_tally - base, 16'h1111);
   endtask
   task automatic t_alt;
      {serial_b_active, timer3_out_en} = 2'b11;
      fp_pin_in = 8'ha3;
      cyc(4);
      chk("fp alts", {timer3_external_io, timer3_capture_trigger_in, serial_b_receive,
         fp_alt_en[3], fp_alt_val[3]}, 5'b11010);
      chk("fp alt en", fp_alt_en, 8'h09);
      chk("fp alt val", fp_alt_val, 8'hf6);
   endtask
   initial begin
      {up_wr_en, ss_wr_en, mem_active, addr_phase_low, serial_a_active, serial_a_transmit} = '0;
      {ext_wr_strobe_n, ext_rd_strobe_n, strobes_active, serial_b_active, serial_b_transmit} = '0;
      {mem_mode, mem_addr, up_wr_data, ss_wr_data, ext_low} = '0;
      {data_phase, data_dir_out, mem_wdata, timer3_out_en, timer3_out_val} = '0;
      fp_pin_in = 8'ha0;
      cyc(8);
      rst = 1'b0;
      cyc(1);
      chk("reset latches", {up_latch, ss_latch}, 16'hffff);
      chk("reset drive", {up_pin_oe | ~up_weak_pu, ss_pin_oe | ~ss_weak_pu}, 16'h0000);
      t_pull;
      t_input;
      t_mem;
      t_irq;
      t_alt;
      close_out;
   end
   // Run needs under ten microseconds
   initial begin
      #20000;
      error_cnt++;
      close_out;
   end
endmodule // quasi_bidir_port_pins_bench
`default_nettype wire
